/* rtl/adr_defines.vh */
// constants for the serial readout of the converter
// assumes REF_CLK at 200 MHz; included by the readout modules
`ifndef ADR_DEFINES_VH
`define ADR_DEFINES_VH

// reference clock rate
`define ADR_REF_CLK_HZ 200000000
// internal conversion oscillator, typical rate
`define ADR_OSC_HZ 4000000
// reference clock cycles per oscillator tick, derived
`define ADR_OSC_DIV (`ADR_REF_CLK_HZ / `ADR_OSC_HZ)
// oscillator ticks that one internal-clock conversion takes
`define ADR_CONV_OSC_TICKS 16
// serial clock rising edges that one external-clock conversion takes
`define ADR_CONV_SCLK_EDGES 8
// serial clock limits, host side
`define ADR_SCLK_MIN_HZ 100000
`define ADR_SCLK_MAX_HZ 4800000
// frame layout: three bytes, 24 bits
`define ADR_FRAME_BITS 24
`define ADR_RESULT_BITS 14
`define ADR_BIT_CNT_W 5
`define ADR_TICK_CNT_W 6

`endif

/* rtl/adr_osc.v */
// internal conversion oscillator: a gated divider of the reference clock
// assumes RUN comes from logic on the same clock; ticks stop when RUN drops
`include "adr_defines.vh"

module adr_osc (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // control
    input wire run,
    // one-cycle tick at the oscillator rate
    output reg tick_ff
);

    // the count is worked out at 32 bits, then cut to the divider width
    localparam [31:0] DIV_LAST_W = `ADR_OSC_DIV - 1;
    localparam [6:0] DIV_LAST = DIV_LAST_W[6:0];

    reg [6:0] div_ff;
    reg [6:0] nxt_div;
    reg nxt_tick;

    // divider held at zero while stopped, so no stray tick on restart
    always @* begin
        nxt_div = 7'h00;
        nxt_tick = 1'b0;
        if (run) begin
            if (div_ff == DIV_LAST) begin
                nxt_tick = 1'b1;
            end else begin
                nxt_div = div_ff + 7'h01;
            end
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_ff <= 7'h00;
            tick_ff <= 1'b0;
        end else begin
            div_ff <= nxt_div;
            tick_ff <= nxt_tick;
        end
    end

endmodule

/* rtl/adr_top.v */
// serial readout side of a successive-approximation converter
// assumes SCLK, CS_N and INT_CLK_MODE are pins; converter data is on REF_CLK
//
// Notes on behaviour
// - conversions timed by serial clock or internal 4 MHz oscillator, per mode.
// - data always shifts out on the external serial clock only.
// - internal mode: oscillator times acquisition and conversion, sclk shifts data.
// - external mode: internal oscillator never runs.
// - one result needs three consecutive 8-bit transfers.
// - byte one zero, byte two result MSB..bit 6, byte three bits 5..0, status.
// - output changes on falling serial edge; host samples on rising edge.
// - chip select rising mid-conversion aborts it and enters shutdown.
`include "adr_defines.vh"

module adr_top (
    // clock and reset
    input wire REF_CLK,
    input wire RESET_N,
    // serial link
    input wire SCLK,
    input wire CS_N,
    output wire DOUT,
    output wire DOUT_OE,
    // mode pin: high selects internal conversion clock
    input wire INT_CLK_MODE,
    // converter core, same clock
    input wire [13:0] CONV_RESULT,
    input wire STATUS_HI,
    input wire STATUS_LO,
    output wire CONV_ACTIVE,
    output wire CONV_DONE,
    output wire CONV_ABORT,
    output wire OSC_RUN,
    output wire POWERED
);

    // one-hot states
    localparam [3:0] ST_SHUT = 4'h1;
    localparam [3:0] ST_CONV = 4'h2;
    localparam [3:0] ST_READ = 4'h4;
    localparam [3:0] ST_DONE = 4'h8;

    // counts taken at 32 bits, then cut on purpose to the counter widths
    localparam [31:0] FRAME_LAST_W = `ADR_FRAME_BITS - 1;
    localparam [31:0] OSC_TICKS_W = `ADR_CONV_OSC_TICKS;
    localparam [31:0] SCLK_EDGES_W = `ADR_CONV_SCLK_EDGES;
    localparam [4:0] FRAME_LAST = FRAME_LAST_W[4:0];
    localparam [5:0] OSC_TICKS = OSC_TICKS_W[5:0];
    localparam [5:0] SCLK_EDGES = SCLK_EDGES_W[5:0];

    // picks the frame bit for a given count of falling edges
    function frame_bit;
        input [23:0] frame;
        input [4:0] cnt;
        begin
            if (cnt > FRAME_LAST) begin
                frame_bit = 1'b0;
            end else begin
                frame_bit = frame[FRAME_LAST - cnt];
            end
        end
    endfunction

    // two-flop synchronisers; the first stages are read only by the second
    reg sclk_m_ff, sclk_s_ff, sclk_d_ff;
    reg cs_m_ff, cs_s_ff;
    reg mode_m_ff, mode_s_ff;

    always @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sclk_m_ff <= 1'b0;
            sclk_s_ff <= 1'b0;
            sclk_d_ff <= 1'b0;
            cs_m_ff <= 1'b1;
            cs_s_ff <= 1'b1;
            mode_m_ff <= 1'b0;
            mode_s_ff <= 1'b0;
        end else begin
            sclk_m_ff <= SCLK;
            sclk_s_ff <= sclk_m_ff;
            sclk_d_ff <= sclk_s_ff;
            cs_m_ff <= CS_N;
            cs_s_ff <= cs_m_ff;
            mode_m_ff <= INT_CLK_MODE;
            mode_s_ff <= mode_m_ff;
        end
    end

    // edges three cycles behind the pin, so each clock phase needs three cycles
    wire sclk_rise = sclk_s_ff & ~sclk_d_ff;
    wire sclk_fall = ~sclk_s_ff & sclk_d_ff;
    wire selected = ~cs_s_ff;

    // frame state, counters and registered outputs
    reg [3:0] state_ff, nxt_state;
    reg int_mode_ff, nxt_int_mode;
    reg [5:0] tick_cnt_ff, nxt_tick_cnt;
    reg [4:0] bit_cnt_ff, nxt_bit_cnt;
    reg [23:0] frame_ff, nxt_frame;
    reg dout_ff, nxt_dout;
    reg done_ff, nxt_done;
    reg abort_ff, nxt_abort;
    wire osc_tick;

    // oscillator only runs in internal mode during a conversion
    wire osc_run = (state_ff == ST_CONV) & int_mode_ff;

    adr_osc u_osc (
        .clk(REF_CLK),
        .reset_n(RESET_N),
        .run(osc_run),
        .tick_ff(osc_tick)
    );

    // frame control and output shifting
    always @* begin
        nxt_state = state_ff;
        nxt_int_mode = int_mode_ff;
        nxt_tick_cnt = tick_cnt_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_frame = frame_ff;
        nxt_dout = dout_ff;
        nxt_done = 1'b0;
        nxt_abort = 1'b0;
        // output moves only on falling serial edges, in any active state
        if (selected && (state_ff != ST_SHUT) && sclk_fall) begin
            nxt_dout = frame_bit(frame_ff, bit_cnt_ff + 5'h01);
            if (bit_cnt_ff <= FRAME_LAST) begin
                nxt_bit_cnt = bit_cnt_ff + 5'h01;
            end
        end
        case (state_ff)
            ST_SHUT: begin
                nxt_dout = 1'b0;
                if (selected) begin
                    // mode is caught once per frame so it cannot change mid-conversion
                    nxt_int_mode = mode_s_ff;
                    nxt_tick_cnt = 6'h00;
                    nxt_bit_cnt = 5'h00;
                    nxt_frame = 24'h000000;
                    nxt_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (!selected) begin
                    // the half-done result is dropped; nothing is latched
                    nxt_abort = 1'b1;
                    nxt_state = ST_SHUT;
                end else if ((int_mode_ff && osc_tick) || (!int_mode_ff && sclk_rise)) begin
                    nxt_tick_cnt = tick_cnt_ff + 6'h01;
                    if ((int_mode_ff && (tick_cnt_ff == OSC_TICKS - 6'h01)) ||
                        (!int_mode_ff && (tick_cnt_ff == SCLK_EDGES - 6'h01))) begin
                        // zero byte, result, then the two status bits
                        nxt_frame = {8'h00, CONV_RESULT, STATUS_HI, STATUS_LO};
                        nxt_done = 1'b1;
                        nxt_state = ST_READ;
                    end
                end
            end
            ST_READ: begin
                if (!selected) begin
                    nxt_state = ST_SHUT;
                end else if (bit_cnt_ff > FRAME_LAST) begin
                    // the last falling edge of the frame has gone by
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: begin
                // extra clocks shift zeros until chip select rises
                nxt_dout = 1'b0;
                if (!selected) begin
                    nxt_state = ST_SHUT;
                end
            end
            default: begin
                nxt_state = ST_SHUT;
            end
        endcase
        // chip select high always returns the link to shutdown
        if (!selected) begin
            nxt_dout = 1'b0;
        end
    end

    always @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_ff <= ST_SHUT;
            int_mode_ff <= 1'b0;
            tick_cnt_ff <= 6'h00;
            bit_cnt_ff <= 5'h00;
            frame_ff <= 24'h000000;
            dout_ff <= 1'b0;
            done_ff <= 1'b0;
            abort_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            int_mode_ff <= nxt_int_mode;
            tick_cnt_ff <= nxt_tick_cnt;
            bit_cnt_ff <= nxt_bit_cnt;
            frame_ff <= nxt_frame;
            dout_ff <= nxt_dout;
            done_ff <= nxt_done;
            abort_ff <= nxt_abort;
        end
    end

    // outputs; status levels decode the state register directly
    assign DOUT = dout_ff;
    assign DOUT_OE = selected & (state_ff != ST_SHUT); // driven only while powered
    assign CONV_ACTIVE = (state_ff == ST_CONV);
    assign CONV_DONE = done_ff;
    assign CONV_ABORT = abort_ff;
    assign OSC_RUN = osc_run;
    assign POWERED = (state_ff != ST_SHUT);

endmodule

/* tb/adr_top_props.sv */
// checker on the readout pins and status outputs of adr_top
// assumes INT_CLK_MODE only moves while chip select is high
module adr_props (
    // clock and reset
    input logic REF_CLK,
    input logic RESET_N,
    // link and status
    input logic SCLK,
    input logic CS_N,
    input logic DOUT,
    input logic DOUT_OE,
    input logic INT_CLK_MODE,
    input logic CONV_ACTIVE,
    input logic CONV_DONE,
    input logic CONV_ABORT,
    input logic OSC_RUN,
    input logic POWERED
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    // oscillator gated to internal-mode conversions
    property p_osc; OSC_RUN |-> CONV_ACTIVE && !$past(CS_N, 3); endproperty
    a_osc: assert property (p_osc) else $error("osc outside conversion");
    property p_ext; !INT_CLK_MODE && !$past(INT_CLK_MODE, 4) |-> !OSC_RUN; endproperty
    a_ext: assert property (p_ext) else $error("osc runs in ext mode");
    property p_int; CONV_ACTIVE && INT_CLK_MODE && $past(CONV_ACTIVE, 2) |-> OSC_RUN; endproperty
    a_int: assert property (p_int) else $error("osc idle in int mode");
    // done is a single pulse after a conversion; abort drops power
    property p_done; CONV_DONE |-> $past(CONV_ACTIVE) ##1 !CONV_DONE; endproperty
    a_done: assert property (p_done) else $error("bad done pulse");
    property p_abort; CONV_ABORT |-> ##[0:2] !POWERED; endproperty
    a_abort: assert property (p_abort) else $error("abort kept power");
    // chip select decides power and drive, allowing for the synchroniser
    property p_cs_hi; CS_N [*5] |-> !DOUT_OE && !POWERED; endproperty
    a_cs_hi: assert property (p_cs_hi) else $error("driven while deselected");
    property p_cs_lo; !CS_N [*5] |-> POWERED && DOUT_OE; endproperty
    a_cs_lo: assert property (p_cs_lo) else $error("not powered when selected");
    // output moves only a few cycles into a low clock phase
    property p_dout; $changed(DOUT) |-> !SCLK && !$past(SCLK, 3); endproperty
    a_dout: assert property (p_dout) else $error("dout moved off falling edge");
endmodule
bind adr_top adr_props adr_props_i (.REF_CLK, .RESET_N, .SCLK, .CS_N, .DOUT, .DOUT_OE,
    .INT_CLK_MODE, .CONV_ACTIVE, .CONV_DONE, .CONV_ABORT, .OSC_RUN, .POWERED);

/* tb/adr_host.sv */
// host serial master model: clock idles low, data taken on rising edges
// assumes dout is meaningful only while dout_oe is high
module adr_host #(
    // 105 ns halves keep the serial clock just under the host rate ceiling
    parameter int HALF_NS = 105,
    parameter int WAKE_NS = 5000000
) (
    // serial link
    output logic sclk,
    output logic cs_n,
    input logic dout,
    input logic dout_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle: clock low, deselected
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    // one frame; a released line reads as ~dout, a 1 since dout is held low when released
    task automatic frame(input int n, input int settle_ns, output logic [23:0] d);
        d = 24'h000000;
        cs_n = 1'b0;
        #(settle_ns);
        for (int i = 0; i < n; i++) begin
            #(HALF_NS) sclk = 1'b1;
            d = {d[22:0], dout_oe ? dout : ~dout};
            #(HALF_NS) sclk = 1'b0;
        end
        #(HALF_NS) cs_n = 1'b1;
        #(WAKE_NS);
    endtask
endmodule

/* tb/adr_serial_readout_bench.sv */
// bench: table of full frames, then overrun clocks, aborts and a mid-frame reset
// assumes converter inputs stay steady through each frame
`include "adr_defines.vh"

module adr_serial_readout_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic int_clk_mode = 1'b0;
    logic [13:0] conv_result = 14'h0000;
    logic status_hi = 1'b0;
    logic status_lo = 1'b0;
    wire sclk, cs_n, dout, dout_oe, conv_active, conv_done, conv_abort, osc_run, powered;
    int err_total = 0;
    int compares = 0;
    int n_done = 0;
    int n_abort = 0;
    int n_osc = 0;
    int n_conv = 0;
    int osc0;
    int conv0;
    logic osc_ok;
    logic [23:0] d;
    // shortest internal conversion in reference cycles
    localparam int OSC_MIN = `ADR_CONV_OSC_TICKS * `ADR_OSC_DIV;
    // rows: mode, result, high status, low status, then the expected frame
    logic [40:0] rows [4] = '{41'h0FFFE_00FFFE, 41'h0A971_00A971, 41'h148D3_0048D3,
        41'h10004_000004};
    always #2.5 ref_clk = ~ref_clk;
    adr_top adr_top_i (.REF_CLK(ref_clk), .RESET_N(reset_n), .SCLK(sclk), .CS_N(cs_n),
        .DOUT(dout), .DOUT_OE(dout_oe), .INT_CLK_MODE(int_clk_mode),
        .CONV_RESULT(conv_result), .STATUS_HI(status_hi), .STATUS_LO(status_lo),
        .CONV_ACTIVE(conv_active), .CONV_DONE(conv_done), .CONV_ABORT(conv_abort),
        .OSC_RUN(osc_run), .POWERED(powered));
    // wake wait shortened so the run stays short
    adr_host #(.WAKE_NS(300)) adr_host_i (.sclk(sclk), .cs_n(cs_n), .dout(dout),
        .dout_oe(dout_oe));
    // pulse counters, plus cycle counts of osc_run and conv_active
    always @(posedge ref_clk) begin
        n_done <= n_done + int'(conv_done === 1'b1);
        n_abort <= n_abort + int'(conv_abort === 1'b1);
        n_osc <= n_osc + int'(osc_run === 1'b1);
        n_conv <= n_conv + int'(conv_active === 1'b1);
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // inputs set on the falling edge, then time for the mode pin to settle
    task automatic run(input logic [16:0] row, input int n, input int settle);
        @(negedge ref_clk);
        {int_clk_mode, conv_result, status_hi, status_lo} = row;
        #100;
        adr_host_i.frame(n, settle, d);
    endtask
    task automatic test_done();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge ref_clk);
        reset_n = 1'b1;
        check({22'h0, dout_oe, powered}, 24'h000000);
        // internal mode waits out the conversion with the clock still
        for (int r = 0; r < 4; r++) begin
            osc0 = n_osc;
            conv0 = n_conv;
            run(rows[r][40:24], 24, rows[r][40] ? 4500 : 100);
            check(d, rows[r][23:0]);
            check(24'(n_done), 24'(r + 1));
            osc_ok = rows[r][40] ? (n_osc - osc0 >= OSC_MIN) : (n_osc == osc0);
            check(24'(osc_ok), 24'h000001);
            check(24'(n_conv - conv0 >= (rows[r][40] ? OSC_MIN : 1)), 24'h000001);
        end
        // two extra clocks shift zeros in behind the status bits
        run(rows[1][40:24], 26, 100);
        check(d, {rows[1][21:0], 2'b00});
        // deselect before the result is latched, external then internal
        run(rows[0][40:24], 3, 100);
        check(d, 24'h000000);
        check(24'(n_abort), 24'h000001);
        run(rows[2][40:24], 0, 1000);
        check(24'(n_abort), 24'h000002);
        check(24'(n_done), 24'h000005);
        // reset in mid-frame: outputs drop, then the held chip select powers up again
        fork
            run(rows[0][40:24], 24, 100);
            begin
                #1500;
                @(negedge ref_clk);
                reset_n = 1'b0;
                @(negedge ref_clk);
                check({22'h0, dout_oe, powered}, 24'h000000);
                repeat (3) @(negedge ref_clk);
                reset_n = 1'b1;
                repeat (5) @(negedge ref_clk);
                check({22'h0, dout_oe, powered}, 24'h000003);
            end
        join
        // enough clocks remain after the reset for one fresh conversion
        check(24'(n_done), 24'h000006);
        test_done();
    end
    // roughly four times the expected run length
    initial begin
        #200000;
        err_total++;
        test_done();
    end
endmodule
